/* File: hw/counter_timer_unit.sv */
`timescale 1ns/10ps
`include "counter_timer_unit_params.svh"

// Overview of operation
// - four identical counter/timer channels, numbered 0 to 3
// - select inputs form channel number, high select is MSB
// - each channel: time constant, control, down counter, prescaler, all 8 bits
// - timer mode: prescaler divides clock by 16 or 256, decrements counter
// - counter mode: each active trigger edge decrements counter, no prescaler
// - time constant follows control word, range 1 to 256, both modes
// - counter loads time constant at start, reloads it at every zero
// - new time constant while running takes effect at next reload
// - read of a channel returns its current down counter value
// - channels 0 to 2 pulse their zero-count output high at zero
// - interrupt-enabled channel requests an interrupt at each zero
// - priority fixed by channel number, channel 0 highest
// - acknowledge picks top requester, drives vector only with priority-in high
// - vector is five programmed bits, two-bit channel code, zero LSB
// - lower priority waits for higher service; higher may nest over lower
// - return-from-interrupt fetch ends the serviced channel's service state
// - control bit 6 selects counter mode, clear selects timer mode
// - control bit 4 selects rising or falling trigger edge
// - control bit 7 enables the zero-count interrupt request
// - reset stops channels, clears enables, idles outputs, priority-out follows in
module counter_timer_unit
  import counter_timer_unit_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_CHIP_EN_N,
  input wire logic I_IORQ_N,
  input wire logic I_RD_N,
  input wire logic I_M1_N,
  input wire logic I_CHAN_SEL_LO,
  input wire logic I_CHAN_SEL_HI,
  input wire logic [7:0] I_DATA_IN,
  input wire logic [3:0] I_EXT_TRIGGER_INPUT,
  input wire logic I_PRIORITY_IN,
  output logic [7:0] O_DATA_OUT,
  output logic O_DATA_OE_N,
  output logic [2:0] O_ZERO_COUNT_PULSE,
  output logic O_INT_REQ_OUT,
  output logic O_INT_REQ_OE_N,
  output logic O_PRIORITY_OUT
);

  bus_ctl_s bus;
  bus_ctl_s bus_d;
  bus_ctl_s next_bus_d;
  logic [1:0] sel;
  logic wr_req;
  logic wr_take;
  logic rd_req;
  logic ack_req;
  logic ack_take;
  logic fetch;
  logic fetch_end;
  logic [7:0] chan_count [`NUM_CHANNELS];
  logic [`NUM_CHANNELS-1:0] zero_evt;
  logic [`NUM_CHANNELS-1:0] int_en;
  logic [`NUM_CHANNELS-1:0] expect_tc;

  assign bus.chip_en_n = I_CHIP_EN_N;
  assign bus.iorq_n = I_IORQ_N;
  assign bus.rd_n = I_RD_N;
  assign bus.m1_n = I_M1_N;
  assign sel = {I_CHAN_SEL_HI, I_CHAN_SEL_LO};

  // bus cycle decode and one-shot strobes
  always_comb begin
    wr_req = !bus.chip_en_n && !bus.iorq_n && bus.rd_n && bus.m1_n;
    rd_req = !bus.chip_en_n && !bus.iorq_n && !bus.rd_n && bus.m1_n;
    ack_req = !bus.iorq_n && !bus.m1_n;
    fetch = !bus.m1_n && !bus.rd_n && bus.iorq_n;
    wr_take = wr_req && !(!bus_d.chip_en_n && !bus_d.iorq_n && bus_d.rd_n && bus_d.m1_n);
    ack_take = ack_req && !(!bus_d.iorq_n && !bus_d.m1_n);
    fetch_end = !fetch && !bus_d.m1_n && !bus_d.rd_n && bus_d.iorq_n;
    next_bus_d = I_CE ? bus : bus_d;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      bus_d <= 4'hF;
    end else begin
      bus_d <= next_bus_d;
    end
  end

  // per-channel logic
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHANNELS; gi++) begin : g_chan
      chan_state_e state;
      chan_state_e next_state;
      ctrl_s ctrl;
      ctrl_s next_ctrl;
      logic [7:0] tc;
      logic [7:0] next_tc;
      logic [7:0] count;
      logic [7:0] next_count;
      logic [7:0] psc;
      logic [7:0] next_psc;
      logic exp_tc;
      logic next_exp_tc;
      logic trig_d;
      logic next_trig_d;
      logic zero;
      logic next_zero;
      logic wr_here;
      logic trig_edge;
      logic psc_tick;
      logic tick;
      logic [7:0] psc_mask;

      always_comb begin
        wr_here = wr_take && (sel == 2'(gi));
        trig_edge = ctrl.edge_rise ? (I_EXT_TRIGGER_INPUT[gi] && !trig_d)
                                   : (!I_EXT_TRIGGER_INPUT[gi] && trig_d);
        psc_mask = ctrl.psc256 ? `PSC_MASK_256 : `PSC_MASK_16;
        psc_tick = (psc & psc_mask) == psc_mask;
        tick = ctrl.cnt_mode ? trig_edge : psc_tick;
        next_state = state;
        next_ctrl = ctrl;
        next_tc = tc;
        next_count = count;
        next_psc = psc;
        next_exp_tc = exp_tc;
        next_trig_d = I_EXT_TRIGGER_INPUT[gi];
        next_zero = 1'b0;
        if (state == CH_RUN) begin
          next_psc = 8'(psc + 8'h01);
          if (tick) begin
            if (count == `COUNT_ONE) begin
              next_count = tc;
              next_zero = 1'b1;
            end else begin
              next_count = 8'(count - 8'h01);
            end
          end
        end
        case (state)
          CH_STOP: next_state = CH_STOP;
          CH_WAIT_TRIG: begin
            if (trig_edge) begin
              next_state = CH_RUN;
              next_psc = 8'h00;
            end
          end
          CH_RUN: next_state = CH_RUN;
          default: next_state = CH_STOP;
        endcase
        if (wr_here && exp_tc) begin
          next_tc = I_DATA_IN;
          next_exp_tc = 1'b0;
          if (state != CH_RUN) begin
            next_count = I_DATA_IN;
            next_psc = 8'h00;
            next_state = (ctrl.trig_start && !ctrl.cnt_mode) ? CH_WAIT_TRIG : CH_RUN;
          end
        end else if (wr_here && I_DATA_IN[0]) begin
          next_ctrl = ctrl_s'(I_DATA_IN);
          next_exp_tc = I_DATA_IN[2];
          if (I_DATA_IN[1]) begin
            next_state = CH_STOP;
            next_zero = 1'b0;
          end
        end
        if (!I_CE) begin
          next_state = state;
          next_ctrl = ctrl;
          next_tc = tc;
          next_count = count;
          next_psc = psc;
          next_exp_tc = exp_tc;
          next_trig_d = trig_d;
          next_zero = zero;
        end
      end

      always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
          state <= CH_STOP;
          ctrl <= `CTRL_RESET;
          tc <= `TC_RESET;
          count <= `COUNT_RESET;
          psc <= 8'h00;
          exp_tc <= 1'b0;
          trig_d <= 1'b0;
          zero <= 1'b0;
        end else begin
          state <= next_state;
          ctrl <= next_ctrl;
          tc <= next_tc;
          count <= next_count;
          psc <= next_psc;
          exp_tc <= next_exp_tc;
          trig_d <= next_trig_d;
          zero <= next_zero;
        end
      end

      assign chan_count[gi] = count;
      assign zero_evt[gi] = next_zero && I_CE;
      assign int_en[gi] = ctrl.int_en;
      assign expect_tc[gi] = exp_tc;
      if (gi < `NUM_ZC_OUTPUTS) begin : g_zc
        assign O_ZERO_COUNT_PULSE[gi] = zero;
      end
    end
  endgenerate

  // interrupt control and data bus
  logic [`NUM_CHANNELS-1:0] pend;
  logic [`NUM_CHANNELS-1:0] next_pend;
  logic [`NUM_CHANNELS-1:0] serv;
  logic [`NUM_CHANNELS-1:0] next_serv;
  logic [`NUM_CHANNELS-1:0] req_ok;
  logic [4:0] vec_base;
  logic [4:0] next_vec_base;
  logic [7:0] data_out;
  logic [7:0] next_data_out;
  logic ack_drive;
  logic next_ack_drive;
  logic seen_prefix;
  logic next_seen_prefix;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [1:0] win;
  logic win_any;
  logic [1:0] serv_top;
  logic return_from_interrupt_op;
  logic blocked;

  always_comb begin
    req_ok = '0;
    win = 2'b00;
    win_any = 1'b0;
    serv_top = 2'b00;
    blocked = 1'b0;
    for (int i = 0; i < `NUM_CHANNELS; i++) begin
      blocked = blocked || serv[i];
      req_ok[i] = pend[i] && !blocked;
      if (req_ok[i] && !win_any) begin
        win = 2'(i);
        win_any = 1'b1;
      end
    end
    for (int i = `NUM_CHANNELS - 1; i >= 0; i--) begin
      if (serv[i]) begin
        serv_top = 2'(i);
      end
    end
    next_seen_prefix = seen_prefix;
    next_op = fetch ? I_DATA_IN : op;
    return_from_interrupt_op = 1'b0;
    if (fetch_end) begin
      next_seen_prefix = (op == `OPCODE_PREFIX);
      return_from_interrupt_op = seen_prefix && (op == `OPCODE_RETURN);
    end
    next_serv = serv;
    next_pend = pend;
    next_ack_drive = ack_drive && ack_req;
    next_data_out = data_out;
    next_vec_base = vec_base;
    if (return_from_interrupt_op && I_PRIORITY_IN && |serv) begin
      next_serv[serv_top] = 1'b0;
    end
    if (ack_take && I_PRIORITY_IN && win_any) begin
      next_serv[win] = 1'b1;
      next_pend[win] = 1'b0;
      next_ack_drive = 1'b1;
      next_data_out = {vec_base, win, 1'b0};
    end
    next_pend = next_pend | (zero_evt & int_en);
    if (rd_req) begin
      next_data_out = chan_count[sel];
    end
    if (wr_take && (sel == 2'b00) && !expect_tc[0] && !I_DATA_IN[0]) begin
      next_vec_base = I_DATA_IN[7:3];
    end
    if (!I_CE) begin
      next_serv = serv;
      next_pend = pend;
      next_ack_drive = ack_drive;
      next_data_out = data_out;
      next_vec_base = vec_base;
      next_seen_prefix = seen_prefix;
      next_op = op;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pend <= '0;
      serv <= '0;
      vec_base <= `VECTOR_RESET;
      data_out <= 8'h00;
      ack_drive <= 1'b0;
      seen_prefix <= 1'b0;
      op <= 8'h00;
    end else begin
      pend <= next_pend;
      serv <= next_serv;
      vec_base <= next_vec_base;
      data_out <= next_data_out;
      ack_drive <= next_ack_drive;
      seen_prefix <= next_seen_prefix;
      op <= next_op;
    end
  end

  assign O_DATA_OUT = data_out;
  assign O_DATA_OE_N = !(rd_req || (ack_req && ack_drive));
  assign O_INT_REQ_OUT = 1'b0;
  assign O_INT_REQ_OE_N = !(I_PRIORITY_IN && |req_ok);
  assign O_PRIORITY_OUT = I_PRIORITY_IN && !(|serv);

endmodule : counter_timer_unit

/* File: hw/counter_timer_unit_params.svh */
`ifndef COUNTER_TIMER_UNIT_PARAMS_SVH
`define COUNTER_TIMER_UNIT_PARAMS_SVH

`define NUM_CHANNELS 4
`define NUM_ZC_OUTPUTS 3
`define CTRL_RESET 8'h00
`define TC_RESET 8'h00
`define COUNT_RESET 8'h00
`define VECTOR_RESET 5'h00
`define PSC_MASK_16 8'h0F
`define PSC_MASK_256 8'hFF
`define COUNT_ONE 8'h01
`define OPCODE_PREFIX 8'hED
`define OPCODE_RETURN 8'h4D

`endif

/* File: hw/counter_timer_unit_pkg.sv */
package counter_timer_unit_pkg;

  typedef enum logic [2:0] {
    CH_STOP = 3'b001,
    CH_WAIT_TRIG = 3'b010,
    CH_RUN = 3'b100
  } chan_state_e;

  typedef struct packed {
    logic int_en;
    logic cnt_mode;
    logic psc256;
    logic edge_rise;
    logic trig_start;
    logic tc_follows;
    logic sw_reset;
    logic is_ctrl;
  } ctrl_s;

  typedef struct packed {
    logic chip_en_n;
    logic iorq_n;
    logic rd_n;
    logic m1_n;
  } bus_ctl_s;

endpackage : counter_timer_unit_pkg

/* File: tb/counter_timer_unit_props.sv */
`timescale 1ns/10ps
module counter_timer_unit_props
  import counter_timer_unit_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_CHIP_EN_N,
  input wire logic I_IORQ_N,
  input wire logic I_RD_N,
  input wire logic I_M1_N,
  input wire logic I_PRIORITY_IN,
  input wire logic [7:0] O_DATA_OUT,
  input wire logic O_DATA_OE_N,
  input wire logic [2:0] O_ZERO_COUNT_PULSE,
  input wire logic O_INT_REQ_OE_N,
  input wire logic O_PRIORITY_OUT
);
  default clocking dc @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  logic ack;
  assign ack = !I_IORQ_N && !I_M1_N;
  chain_block_a:
    assert property (!I_PRIORITY_IN |-> !O_PRIORITY_OUT) else $error("chain not blocked");
  req_gate_a:
    assert property (!I_PRIORITY_IN |-> O_INT_REQ_OE_N) else $error("request without priority");
  reset_idle_a:
    assert property ($fell(I_RESET) |-> O_ZERO_COUNT_PULSE == 3'h0 && O_INT_REQ_OE_N
      && O_PRIORITY_OUT == I_PRIORITY_IN) else $error("outputs not idle after reset");
  zero_single_a:
    assert property (I_CE && O_ZERO_COUNT_PULSE != 3'h0 |=>
      (O_ZERO_COUNT_PULSE & $past(O_ZERO_COUNT_PULSE)) == 3'h0) else $error("zero pulse too long");
  read_drive_a:
    assert property (!I_CHIP_EN_N && !I_IORQ_N && !I_RD_N && I_M1_N |-> !O_DATA_OE_N)
      else $error("read not driven");
  bus_quiet_a:
    assert property (I_IORQ_N |-> O_DATA_OE_N) else $error("bus driven outside cycle");
  vector_even_a:
    assert property (ack && $past(ack) && !O_DATA_OE_N |-> !O_DATA_OUT[0])
      else $error("odd vector");
  ack_serve_a:
    assert property (I_CE && ack && !$past(ack) && I_PRIORITY_IN && !O_INT_REQ_OE_N
      |=> !O_PRIORITY_OUT) else $error("service not blocking chain");
  cover property (O_ZERO_COUNT_PULSE != 3'h0);
  cover property (ack && !O_DATA_OE_N);
  cover property ($rose(O_PRIORITY_OUT));
endmodule : counter_timer_unit_props
bind counter_timer_unit counter_timer_unit_props u_props (.I_CORE_CLK(I_CORE_CLK),
  .I_RESET(I_RESET), .I_CE(I_CE), .I_CHIP_EN_N(I_CHIP_EN_N), .I_IORQ_N(I_IORQ_N),
  .I_RD_N(I_RD_N), .I_M1_N(I_M1_N), .I_PRIORITY_IN(I_PRIORITY_IN), .O_DATA_OUT(O_DATA_OUT),
  .O_DATA_OE_N(O_DATA_OE_N), .O_ZERO_COUNT_PULSE(O_ZERO_COUNT_PULSE),
  .O_INT_REQ_OE_N(O_INT_REQ_OE_N), .O_PRIORITY_OUT(O_PRIORITY_OUT));

/* File: tb/cpu_bus_model.sv */
`timescale 1ns/10ps
module cpu_bus_model
  import counter_timer_unit_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_data,
  output bus_ctl_s o_bus,
  output logic [1:0] o_sel,
  output logic [7:0] o_data
);
  initial begin
    o_bus = '1;
    o_sel = 2'h0;
    o_data = 8'h00;
  end
  // hold a request n edges, take data at the last, release, then one idle edge
  task automatic cyc(input bus_ctl_s b, input logic [1:0] s, input logic [7:0] d,
                     input int n, output logic [7:0] v);
    @(posedge i_clk);
    o_bus <= b;
    o_sel <= s;
    o_data <= d;
    repeat (n) @(posedge i_clk);
    v = i_data;
    o_bus <= '1;
    o_data <= ~d;
    @(posedge i_clk);
  endtask : cyc
  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    logic [7:0] v;
    cyc(4'h3, ch, d, 1, v);
  endtask : wr
  task automatic rd(input logic [1:0] ch, output logic [7:0] v);
    cyc(4'h1, ch, ~o_data, 2, v);
  endtask : rd
  task automatic ack(output logic [7:0] v);
    cyc(4'hA, 2'h0, ~o_data, 2, v);
  endtask : ack
  task automatic return_from_interrupt_op();
    logic [7:0] v;
    cyc(4'hC, 2'h0, 8'hED, 2, v);
    cyc(4'hC, 2'h0, 8'h4D, 2, v);
  endtask : return_from_interrupt_op
endmodule : cpu_bus_model

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top import counter_timer_unit_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic prio_in = 1'b0;
  logic ce = 1'b1;
  logic [3:0] trig = 4'h4;
  bus_ctl_s bus;
  logic [1:0] sel;
  logic [7:0] din, dout, v;
  logic oe_n, int_oe_n, prio_out, int_out;
  logic [2:0] zc;
  int failures = 0;
  int comparisons = 0;
  int cnt[4], tcv[4], zc_exp[3], zc_seen[3];
  int ch, t, n;
  always #10 clk = ~clk;
  cpu_bus_model u_cpu (.i_clk(clk), .i_data(dout), .o_bus(bus), .o_sel(sel), .o_data(din));
  counter_timer_unit u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(ce),
    .I_CHIP_EN_N(bus.chip_en_n), .I_IORQ_N(bus.iorq_n), .I_RD_N(bus.rd_n), .I_M1_N(bus.m1_n),
    .I_CHAN_SEL_LO(sel[0]), .I_CHAN_SEL_HI(sel[1]), .I_DATA_IN(din),
    .I_EXT_TRIGGER_INPUT(trig), .I_PRIORITY_IN(prio_in), .O_DATA_OUT(dout),
    .O_DATA_OE_N(oe_n), .O_ZERO_COUNT_PULSE(zc), .O_INT_REQ_OUT(int_out),
    .O_INT_REQ_OE_N(int_oe_n), .O_PRIORITY_OUT(prio_out));
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) if (zc[i] === 1'b1) zc_seen[i]++;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // toggle the selected triggers out and back, then step the model
  task automatic pulse(input logic [3:0] m);
    @(posedge clk) trig <= trig ^ m;
    @(posedge clk) trig <= trig ^ m;
    @(posedge clk);
    for (int i = 0; i < 4; i++) if (m[i]) begin
      if (cnt[i] == 1) begin
        cnt[i] = tcv[i];
        if (i < 3) zc_exp[i]++;
      end else cnt[i]--;
    end
  endtask : pulse
  task automatic gap(input int exp);
    int k;
    for (k = 0; k < 600 && zc[0] !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    for (k = 1; k < 600 && zc[0] !== 1'b1; k++) @(negedge clk);
    check(9'(k), 9'(exp));
  endtask : gap
  initial begin
    void'($urandom(32'hAC44));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(prio_out, 1'b0);
    check(zc, 3'h0);
    check(oe_n, 1'b1);
    @(posedge clk) prio_in <= 1'b1;
    @(negedge clk);
    check(prio_out, 1'b1);
    for (ch = 0; ch < 4; ch++) begin
      u_cpu.wr(ch, ch == 2 ? 8'h45 : 8'h55);
      t = ch == 3 ? 0 : $urandom_range(6, 1);
      u_cpu.wr(ch, t[7:0]);
      tcv[ch] = t == 0 ? 256 : t;
      cnt[ch] = tcv[ch];
      repeat ($urandom_range(13, 1)) pulse(4'(1 << ch));
      u_cpu.rd(ch, v);
      check(v, 9'(cnt[ch] % 256));
      u_cpu.wr(ch, ch == 2 ? 8'h45 : 8'h55);
      t = $urandom_range(6, 1);
      u_cpu.wr(ch, t[7:0]);
      tcv[ch] = t;
      repeat (cnt[ch] + 1) pulse(4'(1 << ch));
      u_cpu.rd(ch, v);
      check(v, 9'(cnt[ch]));
    end
    // trigger edge while frozen must be lost
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) trig <= trig ^ 4'h1;
    @(posedge clk) trig <= trig ^ 4'h1;
    @(posedge clk) ce <= 1'b1;
    u_cpu.rd(2'h0, v);
    check(v, 9'(cnt[0]));
    for (ch = 0; ch < 3; ch++) check(9'(zc_seen[ch]), 9'(zc_exp[ch]));
    for (n = 0; n < 2; n++) begin
      u_cpu.wr(2'h0, n ? 8'h27 : 8'h1F);
      u_cpu.wr(2'h0, n ? 8'h01 : 8'h02);
      if (n == 0) begin
        // timer waits for its trigger edge before counting
        repeat (20) @(posedge clk);
        u_cpu.rd(2'h0, v);
        check(v, 9'h002);
        pulse(4'h1);
      end
      gap(n ? 256 : 32);
    end
    u_cpu.wr(0, 8'h03);
    u_cpu.wr(0, 8'hA8);
    u_cpu.wr(1, 8'hD7);
    u_cpu.wr(1, 8'h01);
    u_cpu.wr(2, 8'hC7);
    u_cpu.wr(2, 8'h01);
    pulse(4'h6);
    for (ch = 1; ch < 3; ch++) begin
      @(negedge clk);
      check(int_oe_n, 1'b0);
      check(int_out, 1'b0);
      u_cpu.ack(v);
      check(v, {5'h15, ch[1:0], 1'b0});
      @(negedge clk);
      check(prio_out, 1'b0);
      check(int_oe_n, 1'b1);
      u_cpu.return_from_interrupt_op();
      @(negedge clk);
      check(prio_out, 1'b1);
    end
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : tb_top
